// ### inc/mplc_pkg.sv
// Summary of operation
// - Per-port 7-bit queue-two egress limit, reset zero
// - Duplex bit 7 set selects half duplex
// - Flow-control bit 6 set enables pause handling in full duplex only
// - Speed bit 5 set selects 10BT, else 100BT
// - Role bit 6 set selects MAC role
// - Tx invert bit 6 launches on falling edge
// - Rx invert bit 4 inverts driven rx clock
// - Decode limit: 0, 100 and 116-127 full, 1-99 Mbps, 101-115 Kbps
package mplc_pkg;
   // ************************************************************
   // Register indices; byte address is four times the index
   // ************************************************************
   localparam logic [7:0] IDX_Q2_LIMIT_P1 = 8'hbe;
   localparam logic [7:0] IDX_Q2_LIMIT_P2 = 8'hce;
   localparam logic [7:0] IDX_Q2_LIMIT_P3 = 8'hde;
   localparam logic [7:0] IDX_Q2_LIMIT_P4 = 8'hee;
   localparam logic [7:0] IDX_LINK_SETTINGS = 8'hdd;
   localparam logic [7:0] IDX_ROLE_SELECT = 8'hdf;
   localparam logic [7:0] IDX_FIXED_THREE = 8'hef;
   localparam logic [7:0] IDX_CLOCK_PHASE = 8'hff;
   localparam int ADDR_W = 10;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int BIT_HALF_DUPLEX = 7;
   localparam int BIT_FLOW_CTRL = 6;
   localparam int BIT_SPEED_10 = 5;
   localparam int BIT_MAC_ROLE = 6;
   localparam int BIT_TX_INVERT = 6;
   localparam int BIT_RX_INVERT = 4;
   localparam int LIMIT_W = 7;
   localparam int RATE_W = 17;
   // ************************************************************
   // Reset and fixed values
   // ************************************************************
   localparam logic [6:0] LIMIT_RESET = 7'h00;
   localparam logic [4:0] LINK_FIXED_LOW = 5'h15;
   localparam logic [5:0] ROLE_FIXED_LOW = 6'h2c;
   localparam logic [7:0] FIXED_THREE = 8'h32;
   // ************************************************************
   // Rate decode
   // ************************************************************
   localparam logic [6:0] LIMIT_FULL_CODE = 7'h64;
   localparam logic [6:0] LIMIT_KBPS_FIRST = 7'h65;
   localparam logic [6:0] LIMIT_KBPS_LAST = 7'h73;
   localparam logic [16:0] RATE_FULL_KBPS = 17'h186a0;
   localparam logic [16:0] RATE_MBPS_KBPS = 17'h003e8;
   localparam logic [16:0] RATE_STEP_KBPS = 17'h00040;
endpackage

// ### inc/mplc_phase_if.sv
`timescale 1ns/100ps
interface mplc_phase_if;
   logic tx_invert;
   logic rx_invert;
   logic apply;
   logic launch;
   logic rx_clock;
   modport cfg (output tx_invert, output rx_invert, output apply, input launch, input rx_clock);
   modport edge_side (input tx_invert, input rx_invert, input apply, output launch,
      output rx_clock);
endinterface

// ### hw/mplc_ref_clock.sv
`timescale 1ns/100ps
module mplc_ref_clock
   import mplc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Reference clock pin
   input wire logic port_four_tx_ref_clock,
   // Phase settings
   mplc_phase_if.edge_side ph
);
   // ************************************************************
   // Synchroniser and edge finder
   // ************************************************************
   logic sync_a;
   logic sync_b;
   logic sync_c;
   logic tx_invert_act;
   logic rx_invert_act;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         sync_c <= 1'b0;
      end
      else
      begin
         sync_a <= port_four_tx_ref_clock;
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end

   // Active phases only move when no frame is in flight
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_invert_act <= 1'b0;
         rx_invert_act <= 1'b0;
      end
      else if (ph.apply)
      begin
         tx_invert_act <= ph.tx_invert;
         rx_invert_act <= ph.rx_invert;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ph.launch <= 1'b0;
         ph.rx_clock <= 1'b0;
      end
      else
      begin
         ph.launch <= tx_invert_act ? (sync_c & ~sync_b) : (~sync_c & sync_b);
         ph.rx_clock <= sync_b ^ rx_invert_act;
      end
   end
endmodule

// ### hw/mplc_regs.sv
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
module mplc_regs
   import mplc_pkg::*;
#(
   parameter int NUM_PORTS = 4
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Frame activity pins
   input wire logic port_three_frame_busy,
   input wire logic port_four_frame_busy,
   // Port three MAC link settings
   output logic port_three_half_duplex,
   output logic port_three_flow_ctrl,
   output logic port_three_speed_10,
   output logic port_three_mac_role,
   // Port four reduced link clocks
   input wire logic port_four_tx_ref_clock,
   output logic port_four_rx_ref_clock,
   output logic port_four_tx_launch,
   // Queue two egress limits
   output logic [NUM_PORTS*RATE_W-1:0] queue_two_rate_kbps,
   output logic [NUM_PORTS-1:0] queue_two_full_rate
);
   // Only four limit registers exist, so more ports cannot be served
   if (NUM_PORTS < 1 || NUM_PORTS > 4)
   begin : gen_bad_ports
      $error("NUM_PORTS must be 1 to 4");
   end

   // ************************************************************
   // Rate decode
   // ************************************************************
   function automatic logic [RATE_W-1:0] rate_of(input logic [LIMIT_W-1:0] code);
      logic [RATE_W-1:0] r;
      r = RATE_FULL_KBPS;
      if (code != 7'h00 && code < LIMIT_FULL_CODE)
         r = RATE_MBPS_KBPS * {10'h000, code};
      else if (code >= LIMIT_KBPS_FIRST && code <= LIMIT_KBPS_LAST)
         r = RATE_STEP_KBPS * {10'h000, code - LIMIT_FULL_CODE};
      return r;
   endfunction

   // ************************************************************
   // Registers
   // ************************************************************
   localparam logic [7:0] LIMIT_IDX [4] = '{IDX_Q2_LIMIT_P1, IDX_Q2_LIMIT_P2,
      IDX_Q2_LIMIT_P3, IDX_Q2_LIMIT_P4};
   logic [LIMIT_W-1:0] limit [NUM_PORTS];
   logic half_duplex_sw;
   logic flow_ctrl_sw;
   logic speed_10_sw;
   logic mac_role_sw;
   logic tx_invert_sw;
   logic rx_invert_sw;
   logic [7:0] idx;
   logic word_ok;
   logic wr_fire;
   logic setup;
   logic [7:0] next_rdata;
   logic next_err;
   logic [NUM_PORTS-1:0] limit_hit;

   assign idx = paddr[ADDR_W-1:2];
   assign word_ok = (paddr[1:0] == 2'b00);
   assign setup = psel & ~penable;
   assign wr_fire = psel & penable & pready & pwrite & ~pslverr;

   genvar g;
   generate
      for (g = 0; g < NUM_PORTS; g++)
      begin : gen_port
         assign limit_hit[g] = (idx == LIMIT_IDX[g]);
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               limit[g] <= LIMIT_RESET;
            else if (wr_fire && limit_hit[g])
               limit[g] <= pwdata[LIMIT_W-1:0];
         end
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               queue_two_rate_kbps[g*RATE_W +: RATE_W] <= RATE_FULL_KBPS;
               queue_two_full_rate[g] <= 1'b1;
            end
            else
            begin
               queue_two_rate_kbps[g*RATE_W +: RATE_W] <= rate_of(limit[g]);
               queue_two_full_rate[g] <= (limit[g] == 7'h00) || (limit[g] == LIMIT_FULL_CODE)
                  || (limit[g] > LIMIT_KBPS_LAST);
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         half_duplex_sw <= 1'b0;
         flow_ctrl_sw <= 1'b0;
         speed_10_sw <= 1'b0;
         mac_role_sw <= 1'b0;
         tx_invert_sw <= 1'b0;
         rx_invert_sw <= 1'b0;
      end
      else if (wr_fire)
      begin
         // Reserved bits are not stored, so a write cannot disturb them
         if (idx == IDX_LINK_SETTINGS)
         begin
            half_duplex_sw <= pwdata[BIT_HALF_DUPLEX];
            flow_ctrl_sw <= pwdata[BIT_FLOW_CTRL];
            speed_10_sw <= pwdata[BIT_SPEED_10];
         end
         if (idx == IDX_ROLE_SELECT)
            mac_role_sw <= pwdata[BIT_MAC_ROLE];
         if (idx == IDX_CLOCK_PHASE)
         begin
            tx_invert_sw <= pwdata[BIT_TX_INVERT];
            rx_invert_sw <= pwdata[BIT_RX_INVERT];
         end
      end
   end

   // ************************************************************
   // APB read path, no wait states
   // ************************************************************
   always_comb
   begin
      next_rdata = 8'h00;
      next_err = ~word_ok;
      if (idx == IDX_LINK_SETTINGS)
         next_rdata = {half_duplex_sw, flow_ctrl_sw, speed_10_sw, LINK_FIXED_LOW};
      else if (idx == IDX_ROLE_SELECT)
         next_rdata = {1'b0, mac_role_sw, ROLE_FIXED_LOW};
      else if (idx == IDX_FIXED_THREE)
         next_rdata = FIXED_THREE;
      else if (idx == IDX_CLOCK_PHASE)
         next_rdata = {1'b0, tx_invert_sw, 1'b0, rx_invert_sw, 4'h0};
      else if (|limit_hit)
      begin
         for (int i = 0; i < NUM_PORTS; i++)
            if (limit_hit[i])
               next_rdata = {1'b0, limit[i]};
      end
      else
         next_err = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
         pready <= 1'b1;
         pslverr <= next_err;
      end
      else
      begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ************************************************************
   // Frame boundary tracking
   // ************************************************************
   logic three_busy_a;
   logic three_busy_b;
   logic four_busy_a;
   logic four_busy_b;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         three_busy_a <= 1'b0;
         three_busy_b <= 1'b0;
         four_busy_a <= 1'b0;
         four_busy_b <= 1'b0;
      end
      else
      begin
         three_busy_a <= port_three_frame_busy;
         three_busy_b <= three_busy_a;
         four_busy_a <= port_four_frame_busy;
         four_busy_b <= four_busy_a;
      end
   end

   // Switching mid-frame would corrupt the frame on the wire
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_three_half_duplex <= 1'b0;
         port_three_flow_ctrl <= 1'b0;
         port_three_speed_10 <= 1'b0;
         port_three_mac_role <= 1'b0;
      end
      else if (!three_busy_b)
      begin
         port_three_half_duplex <= half_duplex_sw;
         port_three_flow_ctrl <= flow_ctrl_sw & ~half_duplex_sw;
         port_three_speed_10 <= speed_10_sw;
         port_three_mac_role <= mac_role_sw;
      end
   end

   // ************************************************************
   // Port four reference clock handling
   // ************************************************************
   mplc_phase_if ph ();
   assign ph.tx_invert = tx_invert_sw;
   assign ph.rx_invert = rx_invert_sw;
   assign ph.apply = ~four_busy_b;

   mplc_ref_clock u_ref_clock (
      .pclk(pclk),
      .presetn(presetn),
      .port_four_tx_ref_clock(port_four_tx_ref_clock),
      .ph(ph.edge_side)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_four_rx_ref_clock <= 1'b0;
         port_four_tx_launch <= 1'b0;
      end
      else
      begin
         port_four_rx_ref_clock <= ph.rx_clock;
         port_four_tx_launch <= ph.launch;
      end
   end
endmodule

// ### tb/mplc_link_partner.sv
`timescale 1ns/100ps
module mplc_link_partner
(
   // Frame requests
   input wire logic frame3_on,
   input wire logic frame4_on,
   // Link pins
   output logic port_four_tx_ref_clock,
   output logic port_three_frame_busy,
   output logic port_four_frame_busy
);
   // ********
   // Free running reference clock
   // ********
   // Offset keeps its edges clear of pclk edges
   initial
   begin
      port_four_tx_ref_clock = 1'b0;
      #37;
      forever #200 port_four_tx_ref_clock = ~port_four_tx_ref_clock;
   end
   assign port_three_frame_busy = frame3_on;
   assign port_four_frame_busy = frame4_on;
endmodule

// ### tb/mplc_regs_asserts.sv
`timescale 1ns/100ps
module mplc_regs_asserts
   import mplc_pkg::*;
#(
   parameter int NUM_PORTS = 4
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Link and rate outputs
   input wire logic port_three_half_duplex,
   input wire logic port_three_flow_ctrl,
   input wire logic port_four_tx_launch,
   input wire logic [NUM_PORTS*RATE_W-1:0] queue_two_rate_kbps,
   input wire logic [NUM_PORTS-1:0] queue_two_full_rate
);
   // ********
   // Read decode and properties
   // ********
   logic rdv;
   logic [7:0] ridx;
   assign rdv = psel && penable && pready && !pwrite && !pslverr;
   assign ridx = paddr[ADDR_W-1:2];
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_fix;
      rdv && ridx == IDX_FIXED_THREE |-> prdata == 32'h32;
   endproperty
   a_fix: assert property (p_fix) else $error("fixed register read wrong");
   property p_link;
      rdv && ridx == IDX_LINK_SETTINGS |-> (prdata & 32'hffffff1f) == 32'h15;
   endproperty
   a_link: assert property (p_link) else $error("link reserved bits wrong");
   property p_role;
      rdv && ridx == IDX_ROLE_SELECT |-> (prdata & 32'hffffffbf) == 32'h2c;
   endproperty
   a_role: assert property (p_role) else $error("role reserved bits wrong");
   property p_phase;
      rdv && ridx == IDX_CLOCK_PHASE |-> (prdata & 32'hffffffaf) == 32'h0;
   endproperty
   a_phase: assert property (p_phase) else $error("phase reserved bits wrong");
   property p_err;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   a_err: assert property (p_err) else $error("refused access leaks data");
   property p_fc;
      port_three_flow_ctrl |-> !port_three_half_duplex;
   endproperty
   a_fc: assert property (p_fc) else $error("flow control in half duplex");
   property p_full;
      queue_two_full_rate[0] |-> queue_two_rate_kbps[16:0] == RATE_FULL_KBPS;
   endproperty
   a_full: assert property (p_full) else $error("full rate flag mismatch");
   property p_launch;
      $rose(port_four_tx_launch) |=> $fell(port_four_tx_launch);
   endproperty
   a_launch: assert property (p_launch) else $error("launch pulse too long");
   c_fix: cover property (rdv && ridx == IDX_FIXED_THREE);
   c_err: cover property (pslverr);
   c_launch: cover property (port_four_tx_launch ##1 !port_four_tx_launch);
endmodule
bind mplc_regs mplc_regs_asserts #(.NUM_PORTS(NUM_PORTS)) u_mplc_regs_asserts (.*);

// ### tb/mplc_regs_tb.sv
`timescale 1ns/100ps
module mplc_regs_tb;
   import mplc_pkg::*;
   // ********
   // Bench signals
   // ********
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, frame3_on = 1'b0, frame4_on = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, err, port_three_frame_busy, port_four_frame_busy;
   logic port_three_half_duplex, port_three_flow_ctrl, port_three_speed_10, port_three_mac_role;
   logic port_four_tx_ref_clock, port_four_rx_ref_clock, port_four_tx_launch;
   logic [4*RATE_W-1:0] queue_two_rate_kbps;
   logic [3:0] queue_two_full_rate;
   logic [7:0] lim [4] = '{IDX_Q2_LIMIT_P1, IDX_Q2_LIMIT_P2, IDX_Q2_LIMIT_P3, IDX_Q2_LIMIT_P4};
   int bad_count = 0, checks_done = 0;
   always #25 pclk = ~pclk;
   mplc_link_partner u_mplc_link_partner (.*);
   mplc_regs u_mplc_regs (.*);
   // ********
   // Helpers
   // ********
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Ends one edge after release so a following setup never overwrites it
   task automatic apb(logic w, logic [7:0] idx, logic [7:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         bad_count++;
         summarize();
      end
      @(posedge pclk);
   endtask
   task automatic rchk(logic [7:0] idx, logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk($sformatf("reg %h", idx), {24'h0, exp}, rd);
   endtask
   // ********
   // Scenarios
   // ********
   task automatic t_reset();
      rchk(IDX_LINK_SETTINGS, 8'h15);
      rchk(IDX_ROLE_SELECT, 8'h2c);
      rchk(IDX_FIXED_THREE, 8'h32);
      rchk(IDX_CLOCK_PHASE, 8'h00);
      for (int p = 0; p < 4; p++)
         rchk(lim[p], 8'h00);
      chk("link pins", 32'h0, {28'h0, port_three_half_duplex, port_three_flow_ctrl,
         port_three_speed_10, port_three_mac_role});
      chk("full flags", 32'hf, {28'h0, queue_two_full_rate});
      $display("reset test done");
   endtask
   task automatic t_fixed();
      apb(1'b1, IDX_FIXED_THREE, 8'hff);
      rchk(IDX_FIXED_THREE, 8'h32);
      apb(1'b1, IDX_ROLE_SELECT, 8'hff);
      rchk(IDX_ROLE_SELECT, 8'h6c);
      repeat (4) @(posedge pclk);
      chk("mac role", 32'h1, {31'h0, port_three_mac_role});
      apb(1'b1, IDX_ROLE_SELECT, 8'h00);
      repeat (6) @(posedge pclk);
      chk("phy role", 32'h0, {31'h0, port_three_mac_role});
      apb(1'b1, IDX_CLOCK_PHASE, 8'hff);
      rchk(IDX_CLOCK_PHASE, 8'h50);
      apb(1'b0, 8'h00, 8'h00);
      chk("unmapped", 32'h1, {31'h0, err});
      $display("fixed test done");
   endtask
   task automatic t_link();
      logic [7:0] v [4] = '{8'hff, 8'h40, 8'h20, 8'h00};
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, IDX_LINK_SETTINGS, v[i]);
         repeat (6) @(posedge pclk);
         chk("link", {29'h0, v[i][7], v[i][6] & ~v[i][7], v[i][5]}, {29'h0,
            port_three_half_duplex, port_three_flow_ctrl, port_three_speed_10});
         rchk(IDX_LINK_SETTINGS, (v[i] & 8'he0) | 8'h15);
      end
      frame3_on <= 1'b1;
      repeat (5) @(posedge pclk);
      apb(1'b1, IDX_LINK_SETTINGS, 8'h80);
      repeat (6) @(posedge pclk);
      chk("held", 32'h0, {31'h0, port_three_half_duplex});
      frame3_on <= 1'b0;
      repeat (8) @(posedge pclk);
      chk("applied", 32'h1, {31'h0, port_three_half_duplex});
      $display("link test done");
   endtask
   task automatic t_rate();
      logic [6:0] c [8] = '{7'h00, 7'h01, 7'h63, 7'h64, 7'h65, 7'h73, 7'h74, 7'h7f};
      logic [16:0] e;
      int p;
      for (int i = 0; i < 8; i++)
      begin
         p = i % 4;
         e = 17'h186a0;
         if (c[i] >= 7'h01 && c[i] <= 7'h63)
            e = 17'(c[i]) * 17'h003e8;
         if (c[i] >= 7'h65 && c[i] <= 7'h73)
            e = 17'(c[i] - 7'h64) * 17'h00040;
         apb(1'b1, lim[p], {1'b0, c[i]});
         repeat (3) @(posedge pclk);
         chk("rate", {15'h0, e}, {15'h0, queue_two_rate_kbps[p*RATE_W+:RATE_W]});
         chk("full", {31'h0, e == 17'h186a0}, {31'h0, queue_two_full_rate[p]});
         rchk(lim[p], {1'b0, c[i]});
      end
      $display("rate test done");
   endtask
   // Rx clock sampled mid half period after a launch shows which phases are active
   task automatic phase_chk(logic [7:0] v);
      int n;
      n = 0;
      repeat (12) @(posedge pclk);
      while (port_four_tx_launch !== 1'b1 && n < 40)
      begin
         @(posedge pclk);
         n++;
      end
      repeat (2) @(posedge pclk);
      chk("launch", 32'h1, {31'h0, n < 40});
      chk("rx phase", {31'h0, ~v[6] ^ v[4]}, {31'h0, port_four_rx_ref_clock});
   endtask
   task automatic t_phase();
      logic [7:0] v [4] = '{8'h00, 8'h40, 8'h10, 8'h50};
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, IDX_CLOCK_PHASE, v[i]);
         phase_chk(v[i]);
      end
      // A port four frame in flight keeps the old phases until it ends
      frame4_on <= 1'b1;
      repeat (5) @(posedge pclk);
      apb(1'b1, IDX_CLOCK_PHASE, 8'h10);
      phase_chk(8'h50);
      frame4_on <= 1'b0;
      phase_chk(8'h10);
      $display("phase test done");
   endtask
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_fixed();
      t_link();
      t_rate();
      t_phase();
      summarize();
   end
endmodule
